// ---- src/adc_xconv_consts.vh ----
// constants for the extra-conversion control block
// assumes inclusion by bare name from the design file
`ifndef ADC_XCONV_CONSTS_VH
`define ADC_XCONV_CONSTS_VH

// register offsets
`define XC_CTRL_OFFSET 8'hB6
`define XC_STAT_OFFSET 8'hB7

// control field positions
`define XC_REF_HI 7
`define XC_REF_LO 6
`define XC_DEC_HI 5
`define XC_DEC_LO 4
`define XC_CH_HI 3
`define XC_CH_LO 0

// status field positions
`define XC_STAT_PENDING 0
`define XC_STAT_ACTIVE 1

// reset values
`define XC_CTRL_RESET 8'h00_00

// decimation codes and their rates and resolutions
`define XC_DEC_64 2'h0
`define XC_DEC_128 2'h1
`define XC_DEC_256 2'h2
`define XC_DEC_512 2'h3
`define XC_RATE_64 10'h0_040
`define XC_RATE_128 10'h0_080
`define XC_RATE_256 10'h0_100
`define XC_RATE_512 10'h0_200
`define XC_RES_64 4'h7
`define XC_RES_128 4'h9
`define XC_RES_256 4'hA
`define XC_RES_512 4'hC

// channel codes that are not plain pins
`define XC_CH_DIFF_FIRST 4'h8
`define XC_CH_GND 4'hC
`define XC_CH_VREF 4'hD
`define XC_CH_TEMP 4'hE
`define XC_CH_VDD3 4'hF

// input source kinds driven to the analog mux
`define XC_SRC_PIN 3'h0
`define XC_SRC_DIFF 3'h1
`define XC_SRC_GND 3'h2
`define XC_SRC_VREF 3'h3
`define XC_SRC_TEMP 3'h4
`define XC_SRC_VDD3 3'h5

// timing: modulator clocks per decimation step
`define XC_CYCLES_PER_SAMPLE 16'h0_001

`endif

// ---- src/adc_xconv_ctrl.v ----
// control of one software-requested extra conversion of a sigma-delta adc
// assumes a sequencer that reports busy as a level, one clock, sync reset
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "adc_xconv_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Bits 7:6 pick the reference: 00 internal 1.25 V, 01 input 7, 10 supply pin, 11 inputs 6-7 pair.
// - Bits 5:4 pick decimation 64, 128, 256 or 512 with 7, 9, 10 or 12 result bits.
// - The conversion lasts in proportion to the chosen decimation rate.
// - Bits 3:0 pick the channel, and the conversion runs once the running sequence has ended.
// - No extra conversion runs unless the channel field was written since the last one started.
// - With the converter idle, a channel write starts one conversion at once with the extra settings.
// - Hardware clears the channel field to zero when the extra conversion finishes, unless another request is pending.
// - Channel codes 0-7 are single inputs, 8-11 the pairs 0-1 to 6-7, 12 ground, 13 vref, 14 temp, 15 supply/3.
module adc_xconv_ctrl #(
    parameter [15:0] CYCLES_PER_SAMPLE = `XC_CYCLES_PER_SAMPLE
) (
    input wire i_core_clk,
    input wire i_nrst,
    input wire i_ce,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    input wire i_seq_busy,
    output reg o_xconv_active,
    output reg o_xconv_done,
    output reg [1:0] o_ref_code,
    output reg [3:0] o_ref_onehot,
    output reg [9:0] o_dec_rate,
    output reg [3:0] o_res_bits,
    output reg [2:0] o_src_kind,
    output reg [2:0] o_pos_input,
    output reg [2:0] o_neg_input
);

////////////////////////////////////////////////////////////////////////////////
// state machine codes

localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_WAIT = 2'h1;
localparam [1:0] ST_CONV = 2'h2;

////////////////////////////////////////////////////////////////////////////////
// register state

reg [1:0] ref_r;
reg [1:0] dec_r;
reg [3:0] ch_r;
reg pending_r;
reg [1:0] state_r;
reg [1:0] state_nxt;
reg [25:0] cnt_r;

wire ctrl_wr;
wire conv_end;
wire conv_start;
reg [25:0] conv_len;
reg [9:0] rate_nxt;
reg [3:0] res_nxt;
reg [2:0] src_nxt;
reg [2:0] pos_nxt;
reg [2:0] neg_nxt;
reg [3:0] ref_oh_nxt;
wire [7:0] ctrl_word;
wire [7:0] stat_word;

assign ctrl_wr = i_wr && (i_addr == `XC_CTRL_OFFSET);
assign conv_end = (state_r == ST_CONV) && (cnt_r == 26'h000_0001);
// the sequencer owns the converter while busy, so the request waits
assign conv_start = pending_r && !i_seq_busy && (state_r != ST_CONV);
// status shows the live flags, so polling sees the request drop at start
assign ctrl_word = {ref_r, dec_r, ch_r};
assign stat_word = {6'h00, o_xconv_active, pending_r};

////////////////////////////////////////////////////////////////////////////////
// decimation decode

always @* begin
    case (dec_r)
        `XC_DEC_64: begin
            rate_nxt = `XC_RATE_64;
            res_nxt = `XC_RES_64;
        end
        `XC_DEC_128: begin
            rate_nxt = `XC_RATE_128;
            res_nxt = `XC_RES_128;
        end
        `XC_DEC_256: begin
            rate_nxt = `XC_RATE_256;
            res_nxt = `XC_RES_256;
        end
        default: begin
            rate_nxt = `XC_RATE_512;
            res_nxt = `XC_RES_512;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// conversion length

always @* begin
    // duration scales with rate; the analog side supplies no end marker
    conv_len = {16'h0_000, rate_nxt} * {10'h000, CYCLES_PER_SAMPLE};
end

////////////////////////////////////////////////////////////////////////////////
// reference and channel decode

always @* begin
    case (ref_r)
        2'h0: begin
            ref_oh_nxt = 4'h1;
        end
        2'h1: begin
            ref_oh_nxt = 4'h2;
        end
        2'h2: begin
            ref_oh_nxt = 4'h4;
        end
        default: begin
            ref_oh_nxt = 4'h8;
        end
    endcase
end

always @* begin
    pos_nxt = 3'h0;
    neg_nxt = 3'h0;
    if (ch_r < `XC_CH_DIFF_FIRST) begin
        src_nxt = `XC_SRC_PIN;
        pos_nxt = ch_r[2:0];
    end else if (ch_r < `XC_CH_GND) begin
        src_nxt = `XC_SRC_DIFF;
        pos_nxt = {ch_r[1:0], 1'b0};
        neg_nxt = {ch_r[1:0], 1'b1};
    end else begin
        case (ch_r)
            `XC_CH_GND: begin
                src_nxt = `XC_SRC_GND;
            end
            `XC_CH_VREF: begin
                src_nxt = `XC_SRC_VREF;
            end
            `XC_CH_TEMP: begin
                src_nxt = `XC_SRC_TEMP;
            end
            default: begin
                src_nxt = `XC_SRC_VDD3;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// sequencing

always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_IDLE: begin
            if (conv_start) begin
                state_nxt = ST_CONV;
            end else if (pending_r) begin
                state_nxt = ST_WAIT;
            end
        end
        ST_WAIT: begin
            if (conv_start) begin
                state_nxt = ST_CONV;
            end
        end
        ST_CONV: begin
            if (conv_end) begin
                state_nxt = ST_IDLE;
            end
        end
        default: begin
            state_nxt = ST_IDLE;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// sequencer state and length counter

always @(posedge i_core_clk) begin
    if (!i_nrst) begin
        state_r <= ST_IDLE;
        cnt_r <= 26'h000_0000;
    end else if (i_ce) begin
        state_r <= state_nxt;
        // a frozen enable stretches the run by the frozen cycles
        if (conv_start) begin
            cnt_r <= conv_len;
        end else if (state_r == ST_CONV) begin
            cnt_r <= cnt_r - 26'h000_0001;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// control register fields

always @(posedge i_core_clk) begin
    if (!i_nrst) begin
        ref_r <= 2'h0;
        dec_r <= 2'h0;
        ch_r <= 4'h0;
    end else if (i_ce) begin
        // a write in the finishing cycle wins, so that request is kept
        if (ctrl_wr) begin
            ref_r <= i_wdata[`XC_REF_HI:`XC_REF_LO];
            dec_r <= i_wdata[`XC_DEC_HI:`XC_DEC_LO];
            ch_r <= i_wdata[`XC_CH_HI:`XC_CH_LO];
        end else if (conv_end && !pending_r) begin
            // a request queued during the run keeps its channel
            ch_r <= 4'h0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// pending request

always @(posedge i_core_clk) begin
    if (!i_nrst) begin
        pending_r <= 1'b0;
    end else if (i_ce) begin
        if (ctrl_wr) begin
            pending_r <= 1'b1;
        end else if (conv_start) begin
            pending_r <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// run and done flags

always @(posedge i_core_clk) begin
    if (!i_nrst) begin
        o_xconv_active <= 1'b0;
        o_xconv_done <= 1'b0;
    end else if (i_ce) begin
        // done is one cycle, aligned with the fall of active
        o_xconv_done <= conv_end;
        if (conv_start) begin
            o_xconv_active <= 1'b1;
        end else if (conv_end) begin
            o_xconv_active <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// settings handed to the analog side

always @(posedge i_core_clk) begin
    if (!i_nrst) begin
        o_ref_code <= 2'h0;
        o_ref_onehot <= 4'h1;
        o_dec_rate <= `XC_RATE_64;
        o_res_bits <= `XC_RES_64;
        o_src_kind <= `XC_SRC_PIN;
        o_pos_input <= 3'h0;
        o_neg_input <= 3'h0;
    end else if (i_ce && conv_start) begin
        // settings are frozen for the whole conversion
        o_ref_code <= ref_r;
        o_ref_onehot <= ref_oh_nxt;
        o_dec_rate <= rate_nxt;
        o_res_bits <= res_nxt;
        o_src_kind <= src_nxt;
        o_pos_input <= pos_nxt;
        o_neg_input <= neg_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// register read port

always @(posedge i_core_clk) begin
    if (!i_nrst) begin
        o_rdata <= 8'h00;
    end else if (i_ce) begin
        if (i_rd && (i_addr == `XC_CTRL_OFFSET)) begin
            o_rdata <= ctrl_word;
        end else if (i_rd && (i_addr == `XC_STAT_OFFSET)) begin
            o_rdata <= stat_word;
        end else begin
            o_rdata <= 8'h00;
        end
    end
end

endmodule // adc_xconv_ctrl
`default_nettype wire

// ---- verification/xconv_chk_monitor.sv ----
// checker for the extra-conversion control block
// assumes binding onto adc_xconv_ctrl, one clock, sync reset
`timescale 1ns/100ps
`default_nettype none
module xconv_chk #(
    parameter [15:0] CYCLES_PER_SAMPLE = 16'h0001
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic i_seq_busy,
    input wire logic o_xconv_active,
    input wire logic o_xconv_done,
    input wire logic [1:0] o_ref_code,
    input wire logic [3:0] o_ref_onehot,
    input wire logic [9:0] o_dec_rate,
    input wire logic [3:0] o_res_bits,
    input wire logic [2:0] o_src_kind,
    input wire logic [2:0] o_pos_input,
    input wire logic [2:0] o_neg_input
);
default clocking @(posedge i_core_clk); endclocking
default disable iff (!i_nrst);
logic [31:0] cnt_r;
logic pend_r;
wire wr_ctl = i_ce && i_wr && i_addr == 8'hB6;
////////////////////////////////////////////////////////////////////////////////
// bench never writes on a start edge, so one flag is enough
always @(posedge i_core_clk) begin
    cnt_r <= (!i_nrst || !o_xconv_active) ? 32'h0000_0000 : cnt_r + 32'h0000_0001;
    if (!i_nrst)
        pend_r <= 1'b0;
    else if (wr_ctl)
        pend_r <= 1'b1;
    else if ($rose(o_xconv_active))
        pend_r <= 1'b0;
end
////////////////////////////////////////////////////////////////////////////////
ref_sel_a: assert property ($rose(o_xconv_active) |-> o_ref_onehot == 4'h1 << o_ref_code)
    else $error("reference select wrong");
dec_res_a: assert property ($rose(o_xconv_active) |-> o_res_bits == (o_dec_rate == 10'h040 ? 4'h7 :
    o_dec_rate == 10'h080 ? 4'h9 : o_dec_rate == 10'h100 ? 4'hA : 4'hC)) else $error("resolution wrong");
conv_len_a: assert property (o_xconv_done |-> cnt_r == o_dec_rate * CYCLES_PER_SAMPLE)
    else $error("conversion length wrong");
seq_wait_a: assert property ($rose(o_xconv_active) |-> !$past(i_seq_busy))
    else $error("started while sequence busy");
req_only_a: assert property ($rose(o_xconv_active) |-> pend_r)
    else $error("start without request");
idle_start_a: assert property (wr_ctl && !i_seq_busy && !o_xconv_active ##1 i_ce && !i_seq_busy |=> o_xconv_active)
    else $error("idle write did not start");
done_edge_a: assert property (o_xconv_done |-> !o_xconv_active && $past(o_xconv_active))
    else $error("done pulse misplaced");
pair_map_a: assert property (o_xconv_active && o_src_kind == 3'h1 |-> o_neg_input == o_pos_input + 3'h1 && !o_pos_input[0])
    else $error("pair inputs wrong");
cover property ($rose(o_xconv_active) && $past(i_seq_busy, 2));
cover property (o_xconv_done);
cover property (wr_ctl && o_xconv_active);
endmodule // xconv_chk
bind adc_xconv_ctrl xconv_chk #(.CYCLES_PER_SAMPLE(CYCLES_PER_SAMPLE)) xconv_chk_inst (.i_core_clk, .i_nrst, .i_ce,
    .i_addr, .i_wr, .i_seq_busy, .o_xconv_active, .o_xconv_done, .o_ref_code, .o_ref_onehot, .o_dec_rate,
    .o_res_bits, .o_src_kind, .o_pos_input, .o_neg_input);
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the extra-conversion control block
// assumes one 25 MHz clock and a one-sample step
`timescale 1ns/100ps
`default_nettype none
module testbench;
logic i_core_clk, i_nrst, i_ce, i_wr, i_rd, i_seq_busy;
logic [7:0] i_addr, i_wdata;
wire logic [7:0] o_rdata;
wire logic o_xconv_active, o_xconv_done;
wire logic [1:0] o_ref_code;
wire logic [3:0] o_ref_onehot, o_res_bits;
wire logic [9:0] o_dec_rate;
wire logic [2:0] o_src_kind, o_pos_input, o_neg_input;
int miscompares, cmp_count, cyc, n;
logic [27:0] r;
// control byte, one-hot ref, resolution, source, positive, negative
logic [27:0] rows [16] = '{28'h001_7000, 28'h512_9010, 28'hA24_A020, 28'hF38_C030, 28'h041_7040, 28'h552_9050,
    28'hA64_A060, 28'hF78_C070, 28'h081_7101, 28'h592_9123, 28'hAA4_A145, 28'hFB8_C167, 28'h0C1_7200,
    28'h5D2_9300, 28'hAE4_A400, 28'hFF8_C500};
adc_xconv_ctrl #(.CYCLES_PER_SAMPLE(16'h0001)) adc_xconv_ctrl_inst (.i_core_clk, .i_nrst, .i_ce, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_seq_busy, .o_xconv_active, .o_xconv_done, .o_ref_code, .o_ref_onehot,
    .o_dec_rate, .o_res_bits, .o_src_kind, .o_pos_input, .o_neg_input);
////////////////////////////////////////////////////////////////////////////////
task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
        miscompares++;
        $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
endtask
task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
endtask
task rd(input logic [7:0] a, input logic [7:0] e, input string w);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e, w);
endtask
// poll past the edge so the design's update has landed
task wait_act(input bit want);
    n = 0;
    #1;
    while (o_xconv_active !== want && n < 600) begin
        @(posedge i_core_clk);
        #1 n++;
    end
endtask
task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
end
// whole run is about 4100 cycles
always @(posedge i_core_clk) begin
    cyc++;
    if (cyc >= 20000) begin
        miscompares++;
        end_sim;
    end
end
initial begin
    {i_nrst, i_ce, i_wr, i_rd, i_seq_busy, i_addr, i_wdata} = {5'b01000, 16'h0000};
    repeat (2) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    #1 chk(o_ref_onehot, 4'h1, "onehot");
    chk(o_dec_rate, 10'h040, "rate");
    rd(8'hB6, 8'h00, "ctrl");
    wr(8'h10, 8'h01);
    rd(8'h10, 8'h00, "unmapped");
    chk(o_xconv_active, 1'b0, "idle");
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
        r = rows[i];
        wr(8'hB6, r[27:20]);
        wait_act(1'b1);
        chk(n, 1, "start");
        chk(o_ref_code, r[27:26], "refcode");
        chk(o_ref_onehot, r[19:16], "ref");
        chk(o_res_bits, r[15:12], "res");
        chk(o_dec_rate, 10'h040 << r[25:24], "rate");
        chk(o_src_kind, r[11:8], "src");
        chk(o_pos_input, r[7:4], "pos");
        chk(o_neg_input, r[3:0], "neg");
        wait_act(1'b0);
        chk(n, 10'h040 << r[25:24], "length");
        chk(o_xconv_done, 1'b1, "done");
        rd(8'hB6, {r[27:24], 4'h0}, "cleared");
    end
    $display("test table done");
    @(posedge i_core_clk);
    i_seq_busy <= 1'b1;
    wr(8'hB6, 8'h0D);
    repeat (5) @(posedge i_core_clk);
    #1 chk(o_xconv_active, 1'b0, "held");
    rd(8'hB7, 8'h01, "pending");
    @(posedge i_core_clk);
    i_seq_busy <= 1'b0;
    wait_act(1'b1);
    chk(n, 1, "after seq");
    chk(o_src_kind, 3'h3, "vref");
    repeat (10) @(posedge i_core_clk);
    wr(8'hB6, 8'h0C);
    wait_act(1'b0);
    wait_act(1'b1);
    chk(n, 1, "queued start");
    chk(o_src_kind, 3'h2, "queued");
    rd(8'hB7, 8'h02, "active");
    wait_act(1'b0);
    rd(8'hB6, 8'h00, "queued clear");
    $display("test busy done");
    @(posedge i_core_clk);
    i_ce <= 1'b0;
    wr(8'hB6, 8'h03);
    repeat (3) @(posedge i_core_clk);
    i_ce <= 1'b1;
    #1 chk(o_xconv_active, 1'b0, "frozen");
    rd(8'hB7, 8'h00, "frozen pend");
    $display("test enable done");
    wr(8'hB6, 8'h33);
    wait_act(1'b1);
    @(posedge i_core_clk);
    i_nrst <= 1'b0;
    @(posedge i_core_clk);
    i_nrst <= 1'b1;
    #1 chk(o_xconv_active, 1'b0, "reset active");
    chk(o_dec_rate, 10'h040, "reset rate");
    rd(8'hB6, 8'h00, "reset ctrl");
    $display("test mid-run reset done");
    end_sim;
end
endmodule // testbench
`default_nettype wire
